// ===== rtl/dio_pkg.sv
// Contract
// (RULE1) Servo request rising edge turns servo on
// (RULE2) Servo active output follows servo power
// (RULE3) Rights request is a held level input
// (RULE4) Rights status shows granted rights
// (RULE5) Inhibit request edge toggles motion inhibit
// (RULE6) Inhibit status shows motion inhibit state
// (RULE7) Retreat request edge starts retreat return
// (RULE8) Retreat active output during whole return
// (RULE9) Output clear edge resets general outputs
// (RULE10) Emergency status set once stop occurred
// (RULE11) Slot start edge runs slot, running shown
// (RULE12) Slot halt level pauses slot, paused shown
// (RULE13) Program select edge latches numeric input
// (RULE14) Speed select latches numeric input as override
// (RULE15) Sequencer holds numeric input stable during select
// (RULE16) Numeric output shows the requested item
// (RULE17) Program report edge shows program, flag
// (RULE18) Line report edge shows line, flag
// (RULE19) Speed report edge shows override, flag
// (RULE20) Fault report edge shows error, flag
// (RULE21) Level inputs act while on only
// (RULE22) Edge inputs act on rise, hold
// (RULE23) Numeric bus configured by four bit numbers
// (RULE24) One item shown; newest replaces older
// (RULE25) All inputs synchronised before edge detection
package dio_pkg;
	localparam int NUM_W = 16;
	localparam int SLOTS = 32;
	// ----------------------------------------
	// Synchronised input vector layout
	// ----------------------------------------
	localparam int SG_SERVO = 0;
	localparam int SG_RIGHT = 1;
	localparam int SG_INHIB = 2;
	localparam int SG_RETR  = 3;
	localparam int SG_OCLR  = 4;
	localparam int SG_EMG   = 5;
	localparam int SG_PSEL  = 6;
	localparam int SG_SSEL  = 7;
	localparam int SG_PREP  = 8;
	localparam int SG_LREP  = 9;
	localparam int SG_SREP  = 10;
	localparam int SG_FREP  = 11;
	localparam int SG_START = 12;
	localparam int SG_HALT  = 44;
	localparam int SG_NUM   = 76;
	localparam int SG_W     = 92;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_STAT  = 8'h04;
	localparam logic [7:0] OFS_SDONE = 8'h08;
	localparam logic [7:0] OFS_LINE  = 8'h0C;
	localparam logic [7:0] OFS_ERR   = 8'h10;
	localparam logic [7:0] OFS_PROG  = 8'h14;
	localparam logic [7:0] OFS_OVRD  = 8'h18;
	localparam logic [7:0] OFS_IOCFG = 8'h1C;
	localparam logic [7:0] OFS_RUN   = 8'h20;
	localparam logic [7:0] OFS_WAIT  = 8'h24;
	localparam logic [7:0] OFS_GPOUT = 8'h28;
	localparam int CT_RDONE  = 0;
	localparam int CT_EMGCLR = 1;
	localparam int CT_SVOFF  = 2;
	localparam logic [31:0] IOCFG_RST = 32'h0F00_0F00;
	// Report flag positions, one-hot
	localparam int RP_PROG = 0;
	localparam int RP_LINE = 1;
	localparam int RP_SPD  = 2;
	localparam int RP_FLT  = 3;
endpackage

// ===== rtl/dio_sig_if.sv
`timescale 1ns/1ps
interface dio_sig_if;
	import dio_pkg::*;
	logic [SG_W-1:0] lvl;
	logic [SG_W-1:0] rise;
	modport src (output lvl, output rise);
	modport dst (input lvl, input rise);
endinterface

// ===== rtl/dio_in_sync.sv
`timescale 1ns/1ps
module dio_in_sync
	import dio_pkg::*;
(
	input  wire logic            ref_clk,
	input  wire logic            rst_b,
	input  wire logic [SG_W-1:0] raw_in,
	dio_sig_if.src               sig
);
	typedef struct packed {
		logic [SG_W-1:0] s1;
		logic [SG_W-1:0] s2;
		logic [SG_W-1:0] s3;
	} dio_sync_t;

	dio_sync_t st_reg;
	dio_sync_t st_next;

	// ----------------------------------------
	// Two-stage sync, third stage for edges
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.s1 = raw_in; // [RULE25]
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		if (!rst_b) begin
			st_next = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		st_reg <= st_next;
	end

	// Edges taken from the settled stages only
	assign sig.lvl  = st_reg.s2;
	assign sig.rise = st_reg.s2 & ~st_reg.s3; // [RULE25] [RULE22]
endmodule // dio_in_sync

// ===== rtl/dio_top.sv
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module dio_top
	import dio_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	input  wire logic [7:0]       paddr,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             servo_enable_req,
	input  wire logic             control_rights_req,
	input  wire logic             motion_inhibit_req,
	input  wire logic             retreat_req,
	input  wire logic             output_clear_req,
	input  wire logic             emergency_stop_in,
	input  wire logic [SLOTS-1:0] slot_start,
	input  wire logic [SLOTS-1:0] slot_halt,
	input  wire logic             program_select,
	input  wire logic             speed_scale_select,
	input  wire logic [NUM_W-1:0] numeric_bus_in,
	input  wire logic             program_report_req,
	input  wire logic             line_report_req,
	input  wire logic             speed_report_req,
	input  wire logic             fault_report_req,
	output logic                  servo_active,
	output logic                  control_rights_status,
	output logic                  motion_inhibit_status,
	output logic                  retreat_active,
	output logic                  emergency_halt_status,
	output logic      [SLOTS-1:0] slot_running,
	output logic      [SLOTS-1:0] slot_paused,
	output logic      [NUM_W-1:0] numeric_bus_out,
	output logic                  program_report_flag,
	output logic                  line_report_flag,
	output logic                  speed_report_flag,
	output logic                  fault_report_flag,
	output logic      [NUM_W-1:0] gp_out
);
	typedef struct packed {
		logic             servo;
		logic             rights;
		logic             inhibit;
		logic             retreat;
		logic             emg;
		logic [SLOTS-1:0] run;
		logic [SLOTS-1:0] paused;
		logic [NUM_W-1:0] prog;
		logic [NUM_W-1:0] ovrd;
		logic [NUM_W-1:0] line;
		logic [NUM_W-1:0] err;
		logic [NUM_W-1:0] gp;
		logic [31:0]      iocfg;
		logic [NUM_W-1:0] num_out;
		logic [3:0]       rep;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
	} dio_state_t;

	dio_state_t st_reg;
	dio_state_t st_next;

	// ----------------------------------------
	// Numeric field helpers
	// ----------------------------------------
	// Mask of bits first..last; empty if last is below first
	function automatic logic [NUM_W-1:0] dio_fmask(input logic [3:0] first, input logic [3:0] last);
		logic [NUM_W-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_W; i++) begin
			if (i >= int'(first) && i <= int'(last)) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	function automatic logic [NUM_W-1:0] dio_take(input logic [NUM_W-1:0] bus, input logic [31:0] cfg);
		return (bus & dio_fmask(cfg[3:0], cfg[11:8])) >> cfg[3:0]; // [RULE23]
	endfunction

	function automatic logic [NUM_W-1:0] dio_place(input logic [NUM_W-1:0] val, input logic [31:0] cfg);
		return (val << cfg[19:16]) & dio_fmask(cfg[19:16], cfg[27:24]); // [RULE23]
	endfunction

	// ----------------------------------------
	// Input synchroniser
	// ----------------------------------------
	dio_sig_if sig ();

	dio_in_sync u_sync (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.raw_in  ({numeric_bus_in, slot_halt, slot_start, fault_report_req, speed_report_req,
			line_report_req, program_report_req, speed_scale_select, program_select,
			emergency_stop_in, output_clear_req, retreat_req, motion_inhibit_req,
			control_rights_req, servo_enable_req}),
		.sig     (sig.src)
	);

	logic [NUM_W-1:0] num_val;
	logic [SLOTS-1:0] start_rise;
	logic [SLOTS-1:0] halt_lvl;
	logic             acc;
	logic             wr_ok;
	logic             wr_ctrl;
	logic             wr_sdone;

	assign num_val    = dio_take(sig.lvl[SG_NUM +: NUM_W], st_reg.iocfg); // [RULE15]
	assign start_rise = sig.rise[SG_START +: SLOTS];
	assign halt_lvl   = sig.lvl[SG_HALT +: SLOTS];
	// Write lands at the edge where the master sees pready
	assign acc        = psel && penable && st_reg.pready;
	assign wr_ok      = acc && pwrite && !st_reg.pslverr;
	assign wr_ctrl    = wr_ok && paddr == OFS_CTRL;
	assign wr_sdone   = wr_ok && paddr == OFS_SDONE;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic        hit;
		logic [31:0] rd;
		st_next = st_reg;
		hit = 1'b1;
		rd = '0;

		// Software side effects first, so hardware events below win
		if (wr_ok) begin
			case (paddr)
				OFS_CTRL: begin
					if (pwdata[CT_RDONE]) begin
						st_next.retreat = 1'b0;
					end
					if (pwdata[CT_EMGCLR]) begin
						st_next.emg = 1'b0;
					end
					if (pwdata[CT_SVOFF]) begin
						st_next.servo = 1'b0;
					end
				end
				OFS_SDONE: st_next.run = st_reg.run & ~pwdata;
				OFS_LINE:  st_next.line = pwdata[NUM_W-1:0];
				OFS_ERR:   st_next.err = pwdata[NUM_W-1:0];
				OFS_IOCFG: st_next.iocfg = pwdata;
				OFS_GPOUT: st_next.gp = pwdata[NUM_W-1:0];
				default: ;
			endcase
		end

		if (sig.rise[SG_SERVO]) begin
			st_next.servo = 1'b1; // [RULE1] [RULE22]
		end
		st_next.rights = sig.lvl[SG_RIGHT]; // [RULE3] [RULE4] [RULE21]
		if (sig.rise[SG_INHIB]) begin
			st_next.inhibit = !st_reg.inhibit; // [RULE5] [RULE6]
		end
		if (sig.rise[SG_RETR]) begin
			st_next.retreat = 1'b1; // [RULE7] [RULE8]
		end
		if (sig.rise[SG_OCLR]) begin
			st_next.gp = '0; // [RULE9]
		end
		// Emergency drops servo and aborts a retreat; the flag is sticky
		if (sig.lvl[SG_EMG]) begin
			st_next.emg = 1'b1; // [RULE10]
			st_next.servo = 1'b0;
			st_next.retreat = 1'b0;
		end

		st_next.run = st_next.run | start_rise; // [RULE11]
		st_next.paused = halt_lvl; // [RULE12] [RULE21]

		if (sig.rise[SG_PSEL]) begin
			st_next.prog = num_val; // [RULE13]
		end
		if (sig.rise[SG_SSEL]) begin
			st_next.ovrd = num_val; // [RULE14]
		end

		// Fault report has the highest priority on a same-cycle tie
		if (sig.rise[SG_FREP]) begin
			st_next.num_out = dio_place(st_reg.err, st_reg.iocfg); // [RULE20] [RULE16]
			st_next.rep = 4'h1 << RP_FLT; // [RULE24]
		end else if (sig.rise[SG_SREP]) begin
			st_next.num_out = dio_place(st_reg.ovrd, st_reg.iocfg); // [RULE19] [RULE16]
			st_next.rep = 4'h1 << RP_SPD; // [RULE24]
		end else if (sig.rise[SG_LREP]) begin
			st_next.num_out = dio_place(st_reg.line, st_reg.iocfg); // [RULE18] [RULE16]
			st_next.rep = 4'h1 << RP_LINE; // [RULE24]
		end else if (sig.rise[SG_PREP]) begin
			st_next.num_out = dio_place(st_reg.prog, st_reg.iocfg); // [RULE17] [RULE16]
			st_next.rep = 4'h1 << RP_PROG; // [RULE24]
		end

		// APB: one wait cycle, then pready for one cycle
		case (paddr)
			OFS_CTRL:  rd = '0;
			OFS_STAT:  rd = {27'h0, st_reg.emg, st_reg.retreat, st_reg.inhibit, st_reg.rights, st_reg.servo};
			OFS_SDONE: rd = '0;
			OFS_LINE:  rd = {16'h0, st_reg.line};
			OFS_ERR:   rd = {16'h0, st_reg.err};
			OFS_PROG:  rd = {16'h0, st_reg.prog};
			OFS_OVRD:  rd = {16'h0, st_reg.ovrd};
			OFS_IOCFG: rd = st_reg.iocfg;
			OFS_RUN:   rd = st_reg.run;
			OFS_WAIT:  rd = st_reg.paused;
			OFS_GPOUT: rd = {16'h0, st_reg.gp};
			default:   hit = 1'b0;
		endcase
		st_next.pready = psel && penable && !st_reg.pready;
		st_next.pslverr = psel && penable && !st_reg.pready && !hit;
		st_next.prdata = (psel && !pwrite && hit) ? rd : '0;

		if (!rst_b) begin
			st_next = '0;
			st_next.iocfg = IOCFG_RST;
		end
	end

	always_ff @(posedge ref_clk) begin
		st_reg <= st_next;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata                = st_reg.prdata;
	assign pready                = st_reg.pready;
	assign pslverr               = st_reg.pslverr;
	assign servo_active          = st_reg.servo; // [RULE2]
	assign control_rights_status = st_reg.rights;
	assign motion_inhibit_status = st_reg.inhibit;
	assign retreat_active        = st_reg.retreat;
	assign emergency_halt_status = st_reg.emg;
	assign slot_running          = st_reg.run;
	assign slot_paused           = st_reg.paused;
	assign numeric_bus_out       = st_reg.num_out;
	assign program_report_flag   = st_reg.rep[RP_PROG];
	assign line_report_flag      = st_reg.rep[RP_LINE];
	assign speed_report_flag     = st_reg.rep[RP_SPD];
	assign fault_report_flag     = st_reg.rep[RP_FLT];
	assign gp_out                = st_reg.gp;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	a_servo_on_edge: assert property ( // [RULE1]
		sig.rise[SG_SERVO] && !sig.lvl[SG_EMG] |=> servo_active)
		else $error("servo not on after request edge");
	a_servo_hold: assert property ( // [RULE2]
		servo_active && !sig.lvl[SG_EMG] && !wr_ctrl |=> servo_active)
		else $error("servo dropped without cause");
	a_rights_level: assert property ( // [RULE4]
		sig.lvl[SG_RIGHT] |=> control_rights_status)
		else $error("rights status not following request");
	a_rights_drop: assert property ( // [RULE21]
		$fell(sig.lvl[SG_RIGHT]) |=> !control_rights_status)
		else $error("rights status held after request off");
	a_inhibit_toggle: assert property ( // [RULE5]
		sig.rise[SG_INHIB] |=> motion_inhibit_status != $past(motion_inhibit_status))
		else $error("inhibit state did not toggle");
	a_retreat_start: assert property ( // [RULE7]
		sig.rise[SG_RETR] && !sig.lvl[SG_EMG] |=> retreat_active)
		else $error("retreat not started");
	a_outclr_zero: assert property ( // [RULE9]
		sig.rise[SG_OCLR] |=> gp_out == '0)
		else $error("general outputs not cleared");
	a_emg_sticky: assert property ( // [RULE10]
		sig.lvl[SG_EMG] |=> emergency_halt_status && !servo_active ##1 emergency_halt_status)
		else $error("emergency status not held");
	a_slot_start: assert property ( // [RULE11]
		start_rise[0] |=> slot_running[0])
		else $error("slot did not start on edge");
	a_slot_pause: assert property ( // [RULE12]
		halt_lvl[SLOTS-1] |=> slot_paused[SLOTS-1])
		else $error("slot not paused while halt high");
	a_prog_take: assert property ( // [RULE13]
		sig.rise[SG_PSEL] |=> st_reg.prog == $past(num_val))
		else $error("program number not latched");
	a_report_onehot: assert property ( // [RULE24]
		$onehot0(st_reg.rep))
		else $error("more than one report flag");
	a_fault_report: assert property ( // [RULE20]
		sig.rise[SG_FREP] |=> fault_report_flag && numeric_bus_out == dio_place($past(st_reg.err), $past(st_reg.iocfg)))
		else $error("fault number not shown");
	a_apb_wait: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not one wait cycle");

	// ----------------------------------------
	// Hold and priority checks
	// ----------------------------------------
	a_servo_emg: assert property ( // [RULE2]
		sig.lvl[SG_EMG] |=> !servo_active)
		else $error("servo on during emergency");
	a_servo_off: assert property ( // [RULE2]
		wr_ctrl && pwdata[CT_SVOFF] && !sig.rise[SG_SERVO] |=> !servo_active)
		else $error("servo not off after software request");
	a_rights_low: assert property ( // [RULE3]
		!sig.lvl[SG_RIGHT] |=> !control_rights_status)
		else $error("rights status high without request");
	a_inhibit_hold: assert property ( // [RULE6] [RULE22]
		!sig.rise[SG_INHIB] |=> $stable(motion_inhibit_status))
		else $error("inhibit state changed without edge");
	a_retreat_hold: assert property ( // [RULE8]
		retreat_active && !sig.lvl[SG_EMG] && !wr_ctrl |=> retreat_active)
		else $error("retreat ended without cause");
	a_retreat_abort: assert property ( // [RULE8]
		sig.lvl[SG_EMG] |=> !retreat_active)
		else $error("retreat kept during emergency");
	a_emg_hold: assert property ( // [RULE10]
		emergency_halt_status && !wr_ctrl |=> emergency_halt_status)
		else $error("emergency status dropped without clear");
	a_gp_hold: assert property ( // [RULE9]
		!sig.rise[SG_OCLR] && !(wr_ok && paddr == OFS_GPOUT) |=> $stable(gp_out))
		else $error("general outputs changed without cause");
	a_slot_last: assert property ( // [RULE11]
		start_rise[SLOTS-1] |=> slot_running[SLOTS-1])
		else $error("last slot did not start on edge");
	a_slot_hold: assert property ( // [RULE11] [RULE22]
		slot_running[SLOTS-1] && !wr_sdone |=> slot_running[SLOTS-1])
		else $error("slot run dropped without done write");
	a_slot_resume: assert property ( // [RULE21]
		!halt_lvl[0] |=> !slot_paused[0])
		else $error("slot paused with halt low");
	a_ovrd_take: assert property ( // [RULE14]
		sig.rise[SG_SSEL] |=> st_reg.ovrd == $past(num_val))
		else $error("override not latched");
	a_prog_report: assert property ( // [RULE17]
		sig.rise[SG_PREP] && !(|sig.rise[SG_FREP:SG_LREP])
		|=> program_report_flag && numeric_bus_out == dio_place($past(st_reg.prog), $past(st_reg.iocfg)))
		else $error("program number not shown");
	a_line_report: assert property ( // [RULE18]
		sig.rise[SG_LREP] && !(|sig.rise[SG_FREP:SG_SREP])
		|=> line_report_flag && numeric_bus_out == dio_place($past(st_reg.line), $past(st_reg.iocfg)))
		else $error("line number not shown");
	a_speed_report: assert property ( // [RULE19]
		sig.rise[SG_SREP] && !sig.rise[SG_FREP]
		|=> speed_report_flag && numeric_bus_out == dio_place($past(st_reg.ovrd), $past(st_reg.iocfg)))
		else $error("override value not shown");
	a_report_hold: assert property ( // [RULE16] [RULE24]
		!(|sig.rise[SG_FREP:SG_PREP]) |=> $stable(numeric_bus_out) && $stable(st_reg.rep))
		else $error("numeric output changed without request");
	a_apb_error: assert property (
		pslverr |-> pready)
		else $error("slave error outside answer cycle");
endmodule // dio_top

// ===== verif/dio_seq_model.sv
`timescale 1ns/1ps
module dio_seq_model
	import dio_pkg::*;
(
	input  wire logic             ref_clk,
	output logic      [9:0]       ev,
	output logic                  rights,
	output logic                  emg,
	output logic      [SLOTS-1:0] start,
	output logic      [SLOTS-1:0] halt,
	output logic      [NUM_W-1:0] num
);
	initial begin
		{ev, rights, emg, start, halt, num} = '0;
	end

	// ----------------------------------------
	// Sequencer actions, each begun just after a rising edge
	// ----------------------------------------
	// The value is scrambled afterwards so a stale field cannot pass for a fresh one
	task automatic pulse(input int idx, input logic [NUM_W-1:0] v, input logic [SLOTS-1:0] s);
		num <= v;
		start <= s;
		if (idx >= 0) ev[idx] <= 1'b1;
		repeat (4) @(posedge ref_clk);
		ev <= '0;
		start <= '0;
		repeat (2) @(posedge ref_clk);
		num <= ~v;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic level(input logic r, input logic e, input logic [SLOTS-1:0] h);
		rights <= r;
		emg <= e;
		halt <= h;
		repeat (4) @(posedge ref_clk);
	endtask
endmodule // dio_seq_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import dio_pkg::*;
	logic             ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, rights, emg, e;
	logic             servo_active, control_rights_status, motion_inhibit_status, retreat_active;
	logic             emergency_halt_status, program_report_flag, line_report_flag, speed_report_flag;
	logic             fault_report_flag;
	logic [7:0]       paddr;
	logic [9:0]       ev;
	logic [3:0]       m_flg;
	logic [15:0]      m_num, numeric_bus_out, gp_out, num;
	logic [15:0]      val [4];
	logic [31:0]      pwdata, prdata, rd, r, wq, m_run, m_pau, start, halt, slot_running, slot_paused;
	logic [31:0]      seed = 32'h0000_0007;
	int               mismatches = 0, checked = 0, cyc = 0;
	int               m_srv, m_rgt, m_inh, m_ret, m_emg;

	dio_seq_model u_dio_seq_model (.ref_clk, .ev, .rights, .emg, .start, .halt, .num);
	dio_top u_dio_top (.ref_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .servo_enable_req(ev[0]), .motion_inhibit_req(ev[1]), .retreat_req(ev[2]),
		.output_clear_req(ev[3]), .program_select(ev[4]), .speed_scale_select(ev[5]),
		.program_report_req(ev[6]), .line_report_req(ev[7]), .speed_report_req(ev[8]),
		.fault_report_req(ev[9]), .control_rights_req(rights), .emergency_stop_in(emg), .slot_start(start),
		.slot_halt(halt), .numeric_bus_in(num), .servo_active, .control_rights_status, .motion_inhibit_status,
		.retreat_active, .emergency_halt_status, .slot_running, .slot_paused, .numeric_bus_out,
		.program_report_flag, .line_report_flag, .speed_report_flag, .fault_report_flag, .gp_out);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Numeric field sits in bits 4..11 on both sides once configured
	function automatic logic [15:0] take(input logic [15:0] n);
		return (n >> 4) & 16'h00FF;
	endfunction
	function automatic logic [15:0] place(input logic [15:0] v);
		return (v << 4) & 16'h0FF0;
	endfunction

	task automatic give_verdict();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Two edges pass first so register updates from the last action have landed
	task automatic chk_pins();
		repeat (2) @(posedge ref_clk);
		chk({23'h0, fault_report_flag, speed_report_flag, line_report_flag, program_report_flag,
			emergency_halt_status, retreat_active, motion_inhibit_status, control_rights_status, servo_active},
			{23'h0, m_flg, m_emg[0], m_ret[0], m_inh[0], m_rgt[0], m_srv[0]});
		chk(slot_running, m_run);
		chk(slot_paused, m_pau);
		chk({16'h0, numeric_bus_out}, {16'h0, m_num});
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic er);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		// Only pready or the bench cycle ceiling ends this wait
		while (pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge so a following call never rewrites psel in this time step
		@(posedge ref_clk);
	endtask

	// Write answer goes to a scratch word so the caller's data stays intact
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, wq, e);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, rd, e);
		chk(rd, x);
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			give_verdict();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
		{m_srv, m_rgt, m_inh, m_ret, m_emg} = '0;
		{m_flg, m_run, m_pau, m_num} = '0;
		repeat (20) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		chk_pins();
		rdchk(OFS_IOCFG, IOCFG_RST);
		apb(1'b0, 8'h3C, 32'h0, rd, e);
		chk({31'h0, e}, 32'h0000_0001);
		wr(OFS_IOCFG, 32'h0B04_0B04);
		rdchk(OFS_IOCFG, 32'h0B04_0B04);
		for (int k = 0; k < 2; k++) begin
			u_dio_seq_model.pulse(0, 16'h0, '0);
			m_srv = 1;
			u_dio_seq_model.pulse(1, 16'h0, '0);
			m_inh ^= 1;
			chk_pins();
			rdchk(OFS_STAT, {27'h0, 2'b00, m_inh[0], 2'b01});
		end
		u_dio_seq_model.level(1'b1, 1'b0, '0);
		m_rgt = 1;
		chk_pins();
		u_dio_seq_model.level(1'b0, 1'b0, '0);
		m_rgt = 0;
		chk_pins();
		u_dio_seq_model.pulse(2, 16'h0, '0);
		m_ret = 1;
		chk_pins();
		wr(OFS_CTRL, 32'h0000_0001);
		wr(OFS_CTRL, 32'h0000_0004);
		{m_ret, m_srv} = '0;
		chk_pins();
		u_dio_seq_model.pulse(0, 16'h0, '0);
		u_dio_seq_model.level(1'b0, 1'b1, '0);
		m_emg = 1;
		chk_pins();
		wr(OFS_CTRL, 32'h0000_0002);
		chk_pins();
		u_dio_seq_model.level(1'b0, 1'b0, '0);
		wr(OFS_CTRL, 32'h0000_0002);
		m_emg = 0;
		chk_pins();
		r = rnd();
		wr(OFS_GPOUT, r);
		rdchk(OFS_GPOUT, {16'h0, r[15:0]});
		u_dio_seq_model.pulse(3, 16'h0, '0);
		rdchk(OFS_GPOUT, 32'h0);
		chk({16'h0, gp_out}, 32'h0);
		m_pau = rnd();
		u_dio_seq_model.level(1'b0, 1'b0, m_pau);
		m_run = rnd();
		u_dio_seq_model.pulse(-1, 16'h0, m_run);
		chk_pins();
		r = rnd();
		wr(OFS_SDONE, r);
		m_run &= ~r;
		rdchk(OFS_RUN, m_run);
		chk_pins();
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			val[i] = r[15:0];
		end
		for (int i = 0; i < 2; i++) begin
			u_dio_seq_model.pulse(4 + i, val[2 * i], '0);
			val[2 * i] = take(val[2 * i]);
			rdchk(i ? OFS_OVRD : OFS_PROG, {16'h0, val[2 * i]});
		end
		wr(OFS_LINE, {16'h0, val[1]});
		wr(OFS_ERR, {16'h0, val[3]});
		for (int i = 0; i < 4; i++) begin
			u_dio_seq_model.pulse(6 + i, 16'h0, '0);
			m_flg = 4'h1 << i;
			m_num = place(val[i]);
			chk_pins();
		end
		give_verdict();
	end
endmodule // tb_top
